// ===== hw/microword_field_decoder.sv
// Purpose: decode one control-store microword per machine cycle
// Assumes: pclk 250 MHz, microword and operand inputs on pclk
// Notes: tags, index and check-stop switch are pins, synchronised here
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns

// Behaviour
// - ops 0,1: add/sub, carry-in 0/1
// - ops 2,3,7: and, or, xor
// - op 4: carry-out sets carry status bit
// - op 5: carry-in one, load carry bit
// - op 6: carry bit in, carry loaded
// - complement field inverts b operand
// - status field sets/clears bits, nonzero set
// - odd parity over first control group
// - odd parity over second field group
// - bypass puts a on bus, parity-checks
// - high branch forces or tests status/op
// - high branch tests channel tags, carry
// - value eight clears, with DST_SW loads module select
// - low branch forces or tests status/op
// - value five tests zero latch
// - value six loads address from a bus
// - values 8,9,a test channel tags
// - value e tests gated index
// - a source: zero, error reg, stop
// - b source: zero or device reg
// - constant field as b operand
// - next-address field high six bits
// - destination routes d bus, always visible
module microword_field_decoder
  import microword_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [microword_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control store word and operand sources
  input wire logic [microword_pkg::WORD_W-1:0] uword,
  input wire logic uword_valid,
  input wire logic [microword_pkg::DATA_W-1:0] a_reg_data,
  input wire logic a_reg_parity,
  input wire logic [microword_pkg::DATA_W-1:0] b_ext_data,
  // pins from outside the clock domain
  input wire logic [7:0] channel_tag_bits,
  input wire logic index_pulse,
  input wire logic check_stop_sw,
  // decoded results
  output logic [microword_pkg::DATA_W-1:0] d_bus,
  output logic [4:0] dest_sel,
  output logic dest_strobe,
  output logic [7:0] next_address,
  output logic [microword_pkg::MOD_W-1:0] module_sel,
  output logic [7:0] status_bits,
  output logic [microword_pkg::DATA_W-1:0] operation_reg,
  output logic format_reg,
  output logic function_reg,
  output logic [1:0] interface_gate_reg,
  output logic halted,
  output logic data_check
);
  typedef struct packed {
    logic [9:0] sy1;
    logic [9:0] sy2;
    logic [9:0] sy3;
    logic [9:0] syf;
    logic run;
    logic halted;
    logic data_check;
    logic stopped;
    logic [2:0] par_err;
    logic [7:0] st;
    logic carry_l;
    logic zero_l;
    logic [DATA_W-1:0] op_reg;
    logic [DATA_W-1:0] dev_reg;
    logic [DATA_W-1:0] err_reg;
    logic fmt;
    logic fn;
    logic [1:0] ig;
    logic [DATA_W-1:0] d_bus;
    logic [4:0] dest;
    logic dest_vld;
    logic [7:0] next_addr;
    logic [MOD_W-1:0] module_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  // microword fields
  logic [CN_W-1:0] f_cn;
  logic [CD_W-1:0] f_cd;
  logic f_cv;
  alu_op_e f_cc;
  logic [CS_W-1:0] f_cs;
  logic f_by;
  logic [CH_W-1:0] f_ch;
  logic [CL_W-1:0] f_cl;
  logic [CA_W-1:0] f_ca;
  logic [CB_W-1:0] f_cb;
  logic [CK_W-1:0] f_ck;
  logic [DATA_W-1:0] a_bus;
  logic [DATA_W-1:0] b_bus;
  logic [DATA_W-1:0] alu_res;
  logic alu_co;
  logic alu_cset;
  logic alu_cload;
  logic [DATA_W-1:0] d_val;
  logic exec;
  logic hi_bit;
  logic lo_bit;
  logic [2:0] par_bad;
  logic apb_setup;
  logic apb_wr;

  // field extraction
  always_comb begin
    f_cn = uword[CN_LSB +: CN_W];
    f_cd = uword[CD_LSB +: CD_W];
    f_cv = uword[CV_POS];
    f_cc = alu_op_e'(uword[CC_LSB +: CC_W]);
    f_cs = uword[CS_LSB +: CS_W];
    f_by = uword[BY_POS];
    f_ch = uword[CH_LSB +: CH_W];
    f_cl = uword[CL_LSB +: CL_W];
    f_ca = uword[CA_LSB +: CA_W];
    f_cb = uword[CB_LSB +: CB_W];
    f_ck = uword[CK_LSB +: CK_W];
  end

  function automatic logic hi_test(input logic [3:0] ch, input logic [7:0] st,
                                   input logic [7:0] op, input logic [7:0] tag,
                                   input logic carry);
    case (ch)
      4'h0: hi_test = 1'b0;
      4'h1: hi_test = 1'b1;
      4'h2: hi_test = st[0];
      4'h3: hi_test = op[6];
      4'h4: hi_test = st[2];
      4'h5: hi_test = st[4];
      4'h6: hi_test = st[6];
      4'h7: hi_test = tag[7];
      4'h8: hi_test = 1'b0;
      4'h9: hi_test = carry;
      4'ha: hi_test = tag[2];
      4'hb: hi_test = tag[4];
      4'hc: hi_test = tag[6];
      4'hd: hi_test = op[0];
      4'he: hi_test = op[2];
      4'hf: hi_test = op[4];
      default: hi_test = 1'b0;
    endcase
  endfunction

  function automatic logic lo_test(input logic [3:0] cl, input logic [7:0] st,
                                   input logic [7:0] op, input logic [7:0] tag,
                                   input logic zero, input logic idx);
    case (cl)
      4'h0: lo_test = 1'b0;
      4'h1: lo_test = 1'b1;
      4'h2: lo_test = st[3];
      4'h3: lo_test = st[5];
      4'h4: lo_test = st[7];
      4'h5: lo_test = zero;
      4'h8: lo_test = tag[1];
      4'h9: lo_test = tag[3];
      4'ha: lo_test = tag[5];
      4'hb: lo_test = op[1];
      4'hc: lo_test = op[3];
      4'hd: lo_test = op[5];
      4'he: lo_test = idx & st[ST_INDEX_EN];
      4'hf: lo_test = op[7];
      default: lo_test = 1'b0;
    endcase
  endfunction

  // status control: codes 1 to 9 clear when odd, set when even (6 only on a nonzero result); codes a to f clear when even, set when odd
  function automatic logic [7:0] apply_cs(input logic [7:0] st, input logic [3:0] cs,
                                          input logic nz);
    logic [7:0] r;
    r = st;
    case (cs)
      4'h1: r[0] = 1'b0;
      4'h2: r[0] = 1'b1;
      4'h3: r[1] = 1'b0;
      4'h4: r[1] = 1'b1;
      4'h5: r[2] = 1'b0;
      4'h6: r[2] = r[2] | nz;
      4'h7: r[3] = 1'b0;
      4'h8: r[3] = 1'b1;
      4'h9: r[4] = 1'b0;
      4'ha: r[5] = 1'b0;
      4'hb: r[5] = 1'b1;
      4'hc: r[6] = 1'b0;
      4'hd: r[6] = 1'b1;
      4'he: r[7] = 1'b0;
      4'hf: r[7] = 1'b1;
      default: r = st;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] read_reg(input logic [ADDR_W-1:0] a, input state_s s);
    logic [31:0] r;
    r = REG_RESET;
    case (a)
      REG_CTRL: r[CTRL_RUN] = s.run;
      REG_STAT: r[7:0] = {2'b00, s.par_err, s.stopped, s.data_check, s.halted};
      REG_STBITS: r[7:0] = s.st;
      REG_ADDR: r[15:0] = {3'b000, s.module_sel, s.next_addr};
      REG_ERR: r[DATA_W-1:0] = s.err_reg;
      REG_DEV: r[DATA_W-1:0] = s.dev_reg;
      default: r = REG_RESET;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STAT) || (a == REG_STBITS) ||
           (a == REG_ADDR) || (a == REG_ERR) || (a == REG_DEV);
  endfunction

  // operand buses
  always_comb begin
    case (f_ca)
      A_SRC_ZERO, A_SRC_STOP: a_bus = '0;
      A_SRC_ERR: a_bus = s_q.err_reg;
      default: a_bus = a_reg_data;
    endcase
    case (f_cb)
      B_SRC_ZERO: b_bus = '0;
      B_SRC_EXT: b_bus = b_ext_data;
      B_SRC_CONST: b_bus = f_ck;
      B_SRC_DEV: b_bus = s_q.dev_reg;
      default: b_bus = '0;
    endcase
  end

  alu_unit #(
    .W(DATA_W)
  ) u_alu (
    .a_in(a_bus),
    .b_in(b_bus),
    .complement(f_cv),
    .op(f_cc),
    .carry_st(s_q.st[ST_CARRY]),
    .result(alu_res),
    .carry_out(alu_co),
    .carry_set(alu_cset),
    .carry_load(alu_cload)
  );

  always_comb begin
    d_val = f_by ? a_bus : alu_res;
    exec = uword_valid && s_q.run && !s_q.halted;
    hi_bit = hi_test(f_ch, s_q.st, s_q.op_reg, s_q.syf[7:0], s_q.carry_l);
    lo_bit = lo_test(f_cl, s_q.st, s_q.op_reg, s_q.syf[7:0], s_q.zero_l, s_q.syf[8]);
    // each group plus its own bit must hold an odd count of ones
    par_bad[0] = ~^{uword[CV_POS], f_cs, f_cd, f_cc, f_by, uword[PC_POS]};
    par_bad[1] = ~^{f_ca, f_cb, f_ck, f_ch, f_cl, uword[PA_POS], uword[PS_POS]};
    par_bad[2] = ~^{f_cn, uword[PN_POS]};
    apb_setup = psel && !penable;
    apb_wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
  end

  always_comb begin
    s_d = s_q;
    // three-stage synchroniser, value taken once stages two and three agree
    s_d.sy1 = {check_stop_sw, index_pulse, channel_tag_bits};
    s_d.sy2 = s_q.sy1;
    s_d.sy3 = s_q.sy2;
    s_d.syf = (s_q.sy2 & s_q.sy3) | (s_q.syf & (s_q.sy2 ^ s_q.sy3));
    s_d.dest_vld = 1'b0;

    // apb: data latched in setup, zero-wait access phase
    s_d.pready = apb_setup;
    if (apb_setup) begin
      s_d.pslverr = !mapped(paddr) || (paddr[1:0] != 2'b00);
      s_d.prdata = read_reg(paddr, s_q);
    end else begin
      s_d.pslverr = 1'b0;
    end
    // software clears come first so hardware sets in the same cycle win
    if (apb_wr) begin
      case (paddr)
        REG_CTRL: begin
          s_d.run = pwdata[CTRL_RUN];
          if (pwdata[CTRL_RESUME]) begin
            s_d.halted = 1'b0;
            s_d.data_check = 1'b0;
            s_d.stopped = 1'b0;
          end
        end
        REG_STAT: s_d.par_err = s_q.par_err & ~pwdata[STAT_PAR_LSB +: 3];
        REG_ERR: s_d.err_reg = pwdata[DATA_W-1:0];
        default: s_d.err_reg = s_d.err_reg;
      endcase
    end

    if (exec) begin
      s_d.d_bus = d_val;
      s_d.dest = f_cd;
      s_d.dest_vld = 1'b1;
      s_d.zero_l = (d_val == '0);
      s_d.carry_l = alu_co;
      s_d.par_err = s_d.par_err | par_bad;
      s_d.st = apply_cs(s_q.st, f_cs, d_val != '0);
      if (alu_cset) begin
        s_d.st[ST_CARRY] = 1'b1;
      end
      if (alu_cload) begin
        s_d.st[ST_CARRY] = alu_co;
      end
      case (f_cd)
        DST_OP: s_d.op_reg = d_val;
        DST_DR: s_d.dev_reg = d_val;
        DST_FT: s_d.fmt = f_cn[0];
        DST_FC: s_d.fn = f_cn[0];
        DST_IG: s_d.ig = {2{f_cn[0]}};
        default: s_d.fmt = s_d.fmt;
      endcase
      if (f_cl == CL_XA) begin
        s_d.next_addr = a_bus;
      end else begin
        s_d.next_addr = {f_cn, hi_bit, lo_bit};
      end
      if (f_ch == CH_MODSW && f_cd == DST_SW) begin
        s_d.module_sel = f_ck[MOD_W-1:0];
      end
      // a mismatch stops execution until software resumes
      if (f_by && (a_reg_parity != ~^a_bus)) begin
        s_d.data_check = 1'b1;
        s_d.halted = 1'b1;
      end
      if (f_ca == A_SRC_STOP && s_q.syf[9]) begin
        s_d.stopped = 1'b1;
        s_d.halted = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign d_bus = s_q.d_bus;
  assign dest_sel = s_q.dest;
  assign dest_strobe = s_q.dest_vld;
  assign next_address = s_q.next_addr;
  assign module_sel = s_q.module_sel;
  assign status_bits = s_q.st;
  assign operation_reg = s_q.op_reg;
  assign format_reg = s_q.fmt;
  assign function_reg = s_q.fn;
  assign interface_gate_reg = s_q.ig;
  assign halted = s_q.halted;
  assign data_check = s_q.data_check;
endmodule

// ===== hw/microword_pkg.sv
// Purpose: shared constants for the microword field decoder
// Assumes: 47-bit microword, field lsb positions below, 8-bit data path
// Notes: apb offsets are byte addresses of aligned 32-bit words
package microword_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 47;
  localparam int ADDR_W = 12;

  // field lsb positions and widths inside the microword
  localparam int CN_LSB = 0;
  localparam int CN_W = 6;
  localparam int PN_POS = 6;
  localparam int CD_LSB = 7;
  localparam int CD_W = 5;
  localparam int CV_POS = 12;
  localparam int CC_LSB = 13;
  localparam int CC_W = 3;
  localparam int CS_LSB = 16;
  localparam int CS_W = 4;
  localparam int PC_POS = 20;
  localparam int PS_POS = 21;
  localparam int BY_POS = 22;
  localparam int CH_LSB = 23;
  localparam int CH_W = 4;
  localparam int CL_LSB = 27;
  localparam int CL_W = 4;
  localparam int CA_LSB = 31;
  localparam int CA_W = 5;
  localparam int CB_LSB = 36;
  localparam int CB_W = 2;
  localparam int CK_LSB = 38;
  localparam int CK_W = 8;
  localparam int PA_POS = 46;
  localparam int MOD_W = 5;

  typedef enum logic [2:0] {
    ALU_ADD_C0 = 3'h0,
    ALU_ADD_C1 = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR = 3'h3,
    ALU_ADD_SET = 3'h4,
    ALU_ADD_LOAD = 3'h5,
    ALU_ADD_CHAIN = 3'h6,
    ALU_XOR = 3'h7
  } alu_op_e;

  localparam logic [4:0] A_SRC_ZERO = 5'h00;
  localparam logic [4:0] A_SRC_ERR = 5'h0d;
  localparam logic [4:0] A_SRC_STOP = 5'h11;
  localparam logic [1:0] B_SRC_ZERO = 2'h0;
  localparam logic [1:0] B_SRC_EXT = 2'h1;
  localparam logic [1:0] B_SRC_CONST = 2'h2;
  localparam logic [1:0] B_SRC_DEV = 2'h3;

  localparam logic [4:0] DST_OP = 5'h08;
  localparam logic [4:0] DST_DR = 5'h0c;
  localparam logic [4:0] DST_FT = 5'h0d;
  localparam logic [4:0] DST_FC = 5'h0e;
  localparam logic [4:0] DST_IG = 5'h0f;
  localparam logic [4:0] DST_SW = 5'h10;

  localparam logic [3:0] CH_MODSW = 4'h8;
  localparam logic [3:0] CL_XA = 4'h6;

  localparam int ST_INDEX_EN = 1;
  localparam int ST_NZ = 2;
  localparam int ST_CARRY = 3;

  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] REG_STBITS = 12'h008;
  localparam logic [ADDR_W-1:0] REG_ADDR = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_ERR = 12'h010;
  localparam logic [ADDR_W-1:0] REG_DEV = 12'h014;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_RESUME = 1;
  localparam int STAT_HALT = 0;
  localparam int STAT_DCHK = 1;
  localparam int STAT_STOP = 2;
  localparam int STAT_PAR_LSB = 3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// ===== hw/alu_unit.sv
// Purpose: eight-function alu with true or complement b operand
// Assumes: purely combinational, one result per machine cycle
// Notes: carry status update is reported, the caller owns the bit
`timescale 1ns/1ns
module alu_unit
  import microword_pkg::*;
#(
  parameter int W = DATA_W
) (
  // operands
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  input wire logic complement,
  input wire microword_pkg::alu_op_e op,
  input wire logic carry_st,
  // results
  output logic [W-1:0] result,
  output logic carry_out,
  output logic carry_set,
  output logic carry_load
);
  logic [W-1:0] b_eff;
  logic cin;
  logic [W:0] sum;

  always_comb begin
    b_eff = complement ? ~b_in : b_in;
    case (op)
      ALU_ADD_C1, ALU_ADD_LOAD: cin = 1'b1;
      ALU_ADD_CHAIN: cin = carry_st;
      default: cin = 1'b0;
    endcase
    sum = {1'b0, a_in} + {1'b0, b_eff} + {{W{1'b0}}, cin};
    carry_out = 1'b0;
    case (op)
      ALU_AND: result = a_in & b_eff;
      ALU_OR: result = a_in | b_eff;
      ALU_XOR: result = a_in ^ b_eff;
      default: begin
        result = sum[W-1:0];
        carry_out = sum[W];
      end
    endcase
    // opcodes 0 and 1 leave the carry status alone
    carry_set = (op == ALU_ADD_SET) && sum[W];
    carry_load = (op == ALU_ADD_LOAD) || (op == ALU_ADD_CHAIN);
  end
endmodule

// ===== test/mfd_sva.sv
// Purpose: port checks for the microword field decoder
// Assumes: one pclk domain, presetn async active low
// Notes: dest_strobe marks the word taken one edge back
`timescale 1ns/1ns
module mfd_sva
  import microword_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // word side
  input wire logic [microword_pkg::WORD_W-1:0] uword,
  input wire logic [microword_pkg::DATA_W-1:0] a_reg_data,
  input wire logic a_reg_parity,
  // results
  input wire logic [microword_pkg::DATA_W-1:0] d_bus,
  input wire logic dest_strobe,
  input wire logic [7:0] next_address,
  input wire logic [7:0] status_bits,
  input wire logic halted,
  input wire logic data_check
);
  logic [4:0] ca;
  logic [3:0] cl;
  logic [3:0] cs;
  logic [7:0] k;
  logic [5:0] cn;
  logic ga;
  logic w_and;
  logic w_c1;
  logic w_by;
  logic w_bad;
  logic w_m8;
  assign ca = uword[CA_LSB+:CA_W];
  assign cl = uword[CL_LSB+:CL_W];
  assign cs = uword[CS_LSB+:CS_W];
  assign k = uword[CK_LSB+:CK_W];
  assign cn = uword[CN_LSB+:CN_W];
  // pin a, constant b, true form, alu to bus
  assign ga = ca == 5'h01 && uword[CB_LSB+:CB_W] == B_SRC_CONST && !uword[CV_POS]
    && !uword[BY_POS];
  assign w_and = ga && uword[CC_LSB+:CC_W] == ALU_AND;
  assign w_c1 = ga && uword[CC_LSB+:CC_W] == ALU_ADD_C1;
  assign w_by = uword[BY_POS] && ca == 5'h01;
  assign w_bad = w_by && a_reg_parity == ^a_reg_data;
  assign w_m8 = uword[CH_LSB+:CH_W] == CH_MODSW;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_and;
    dest_strobe && $past(w_and) |-> d_bus == ($past(a_reg_data) & $past(k));
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_c1;
    dest_strobe && $past(w_c1) |-> d_bus == $past(a_reg_data) + $past(k) + 8'h01;
  endproperty
  a_c1: assert property (p_c1) else $error("add with carry one wrong");
  property p_byp;
    dest_strobe && $past(w_by) |-> d_bus == $past(a_reg_data);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass data wrong");
  property p_dchk;
    dest_strobe && $past(w_bad) |-> ##[0:1] halted && data_check;
  endproperty
  a_dchk: assert property (p_dchk) else $error("no data check stop");
  property p_nz;
    $fell(status_bits[ST_NZ]) |-> $past(cs) == 4'h5;
  endproperty
  a_nz: assert property (p_nz) else $error("nonzero bit cleared wrongly");
  property p_cn;
    dest_strobe && $past(cl) != CL_XA |-> next_address[7:2] == $past(cn);
  endproperty
  a_cn: assert property (p_cn) else $error("next address field wrong");
  property p_cl;
    dest_strobe && $past(cl) < 4'h2 |-> next_address[0] == $past(cl[0]);
  endproperty
  a_cl: assert property (p_cl) else $error("forced low bit wrong");
  property p_m8;
    dest_strobe && $past(w_m8) && $past(cl) != CL_XA |-> !next_address[1];
  endproperty
  a_m8: assert property (p_m8) else $error("high bit not cleared");
  property p_halt;
    $past(halted) |-> !dest_strobe;
  endproperty
  a_halt: assert property (p_halt) else $error("word taken while halted");
endmodule
bind microword_field_decoder mfd_sva u_mfd_sva (.pclk, .presetn, .uword, .a_reg_data,
  .a_reg_parity, .d_bus, .dest_strobe, .next_address, .status_bits, .halted, .data_check);

// ===== test/ctrl_store_model.sv
// Purpose: control store model, fills the parity bits of a word
// Assumes: raw carries the fields and PA_POS, the PN, PC and PS positions are ignored
// Notes: corrupt_pc flips group-one parity for fault scenarios
`timescale 1ns/1ns
module ctrl_store_model
  import microword_pkg::*;
(
  // field image and fault control
  input wire logic [microword_pkg::WORD_W-1:0] raw,
  input wire logic corrupt_pc,
  // word to the decoder
  output logic [microword_pkg::WORD_W-1:0] uword
);
  always_comb begin
    uword = raw;
    uword[PN_POS] = ~^raw[CN_LSB+:CN_W];
    uword[PC_POS] = corrupt_pc ^ ~^{raw[CV_POS], raw[CS_LSB+:CS_W], raw[CD_LSB+:CD_W],
      raw[CC_LSB+:CC_W], raw[BY_POS]};
    uword[PS_POS] = ~^{raw[CA_LSB+:CA_W], raw[CB_LSB+:CB_W], raw[CK_LSB+:CK_W],
      raw[CH_LSB+:CH_W], raw[CL_LSB+:CL_W], raw[PA_POS]};
  end
endmodule

// ===== test/test_microword_field_decoder.sv
// Purpose: self-checking bench for the microword field decoder
// Assumes: a word takes effect one edge on, apb waits on pready
// Notes: tag pins are driven once, together with the index pin
`timescale 1ns/1ns
module test_microword_field_decoder;
  import microword_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [WORD_W-1:0] raw = '0;
  logic [WORD_W-1:0] uword;
  logic corrupt_pc = 1'h0;
  logic uword_valid = 1'h0;
  logic [7:0] a_reg_data = 8'hc3;
  logic a_reg_parity = 1'h1;
  logic index_pulse = 1'h0;
  logic check_stop_sw = 1'h0;
  logic [7:0] d_bus;
  logic [7:0] next_address;
  logic [7:0] status_bits;
  logic [4:0] module_sel;
  logic dest_strobe;
  logic halted;
  logic data_check;
  logic [7:0] tags = 8'h00;
  logic [7:0] op_q;
  logic [4:0] dest_sel;
  logic fmt;
  logic fnr;
  logic [1:0] gate;
  logic st3;
  logic [8:0] r;
  logic [4:0] sca [5] = '{5'h0d, 5'h00, 5'h00, 5'h01, 5'h00};
  logic [1:0] scb [5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h3};
  logic [7:0] sdv [5] = '{8'h3c, 8'h5a, 8'h81, 8'hc3, 8'hc3};
  int fail_count = 0;
  int samples_checked = 0;
  always #2 pclk = ~pclk;
  ctrl_store_model u_ctrl_store_model (.raw, .corrupt_pc, .uword);
  microword_field_decoder u_microword_field_decoder (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .uword, .uword_valid,
    .a_reg_data, .a_reg_parity, .b_ext_data(8'h81), .channel_tag_bits(tags),
    .index_pulse, .check_stop_sw, .d_bus, .dest_sel, .dest_strobe, .next_address,
    .module_sel, .status_bits, .operation_reg(op_q), .format_reg(fmt), .function_reg(fnr),
    .interface_gate_reg(gate), .halted, .data_check);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // pready is read before this edge's own update lands; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic ee);
    logic [31:0] d;
    logic x;
    apb(1'h0, a, 32'h0, d, x);
    chk(d & m, e);
    chk(32'(x), 32'(ee));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic x;
    apb(1'h1, a, v, d, x);
    chk(32'(x), 32'h0);
  endtask
  // one word, then a free edge: the store answers slowly too
  task automatic ex(input logic [WORD_W-1:0] w, input logic bad = 1'h0);
    @(posedge pclk);
    raw <= w;
    corrupt_pc <= bad;
    uword_valid <= 1'h1;
    @(posedge pclk);
    uword_valid <= 1'h0;
    @(negedge pclk);
  endtask
  function automatic logic [WORD_W-1:0] mk(input logic [2:0] cc, input logic cv,
      input logic [3:0] cs, input logic by, input logic [3:0] ch, input logic [3:0] cl,
      input logic [4:0] ca, input logic [1:0] cb, input logic [4:0] cd, input logic [5:0] cn);
    return {1'h0, 8'h5a, cb, ca, cl, ch, by, 2'h0, cs, cc, cv, cd, 1'h0, cn};
  endfunction
  function automatic logic [WORD_W-1:0] wc(input logic [3:0] cs, input logic [3:0] cl);
    return mk(3'h3, 1'h0, cs, 1'h0, 4'h0, cl, 5'h01, 2'h2, 5'h00, 6'h00);
  endfunction
  // a is the pin value c3, b the constant 5a
  function automatic logic [8:0] alu(input logic [2:0] op, input logic cv, input logic c);
    logic [7:0] b;
    logic ci;
    b = cv ? 8'ha5 : 8'h5a;
    ci = op == 3'h6 ? c : op[0];
    case (op)
      3'h2: return {1'h0, 8'hc3 & b};
      3'h3: return {1'h0, 8'hc3 | b};
      3'h7: return {1'h0, 8'hc3 ^ b};
      default: return {1'h0, 8'hc3} + {1'h0, b} + {8'h00, ci};
    endcase
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    ex(wc(4'h6, 4'h1));
    chk(32'(dest_strobe), 32'h0);
    chk(32'(status_bits), 32'h0);
    rd(REG_CTRL, '1, REG_RESET, 1'h0);
    rd(REG_STAT, '1, REG_RESET, 1'h0);
    rd(12'h0ff, '1, 32'h0, 1'h1);
    wr(REG_ERR, 32'h3c);
    rd(REG_ERR, 32'hff, 32'h3c, 1'h0);
    wr(REG_CTRL, 32'h1);
    st3 = 1'h0;
    for (int i = 0; i < 16; i++) begin
      r = alu(i[3:1], i[0], st3);
      ex(mk(i[3:1], i[0], 4'h0, 1'h0, {3'h0, i[0]}, {3'h0, !i[0]}, 5'h01, 2'h2, 5'h00, 6'(i)));
      if (i[3:1] == 3'h4) st3 = st3 | r[8];
      else if (i[3:1] inside {3'h5, 3'h6}) st3 = r[8];
      chk(32'(d_bus), 32'(r[7:0]));
      chk(32'(status_bits[ST_CARRY]), 32'(st3));
      chk({24'h0, 6'(i), i[0], !i[0]}, 32'(next_address));
    end
    ex(wc(4'h0, 4'h2));
    chk(32'(next_address[0]), 32'(st3));
    for (int i = 0; i < 3; i++) begin
      ex(mk(3'h2, 1'h0, i == 2 ? 4'h5 : 4'h6, 1'h0, 4'h0, 4'h0, 5'h01,
        i == 1 ? 2'h0 : 2'h2, 5'h00, 6'h00));
      chk(32'(status_bits[ST_NZ]), 32'(i < 2));
    end
    for (int i = 0; i < 5; i++) begin
      ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'h0, 4'h0, sca[i], scb[i], i == 3 ? DST_DR : 5'h00,
        6'h00));
      chk(32'(d_bus), 32'(sdv[i]));
    end
    rd(REG_DEV, 32'hff, 32'hc3, 1'h0);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, CH_MODSW, 4'h0, 5'h01, 2'h2, DST_SW, 6'h00));
    chk(32'(module_sel), 32'h1a);
    ex(wc(4'h0, CL_XA));
    chk(32'(next_address), 32'hc3);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'h0, 4'h0, 5'h01, 2'h2, DST_OP, 6'h00));
    chk(32'(op_q), 32'hdb);
    chk(32'(dest_sel), 32'(DST_OP));
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'he, 4'hc, 5'h01, 2'h2, DST_FT, 6'h01));
    chk(32'(next_address[1:0]), 32'h1);
    chk(32'(fmt), 32'h1);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'h3, 4'hb, 5'h01, 2'h2, DST_FC, 6'h01));
    chk(32'(next_address[1:0]), 32'h3);
    chk(32'(fnr), 32'h1);
    // add with carry out, then a zero result: latches feed the next word's branch
    ex(mk(3'h0, 1'h0, 4'h0, 1'h0, 4'h0, 4'h0, 5'h01, 2'h2, DST_IG, 6'h01));
    chk(32'(gate), 32'h3);
    ex(mk(3'h2, 1'h0, 4'h0, 1'h0, 4'h9, 4'h5, 5'h01, 2'h0, 5'h00, 6'h00));
    chk(32'(next_address[1:0]), 32'h2);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'h9, 4'h5, 5'h01, 2'h2, 5'h00, 6'h00));
    chk(32'(next_address[1:0]), 32'h1);
    @(posedge pclk);
    index_pulse <= 1'h1;
    tags <= 8'ha2;
    repeat (6) @(posedge pclk);
    ex(wc(4'h0, 4'he));
    chk(32'(next_address[0]), 32'h0);
    ex(wc(4'h4, 4'h0));
    ex(wc(4'h0, 4'he));
    chk(32'(next_address[0]), 32'h1);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'h7, 4'h8, 5'h01, 2'h2, 5'h00, 6'h00));
    chk(32'(next_address[1:0]), 32'h3);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'ha, 4'h9, 5'h01, 2'h2, 5'h00, 6'h00));
    chk(32'(next_address[1:0]), 32'h0);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'hb, 4'ha, 5'h01, 2'h2, 5'h00, 6'h00));
    chk(32'(next_address[1:0]), 32'h1);
    ex(wc(4'h0, 4'h0), 1'h1);
    rd(REG_STAT, 32'h18, 32'h08, 1'h0);
    wr(REG_STAT, 32'h08);
    rd(REG_STAT, 32'h18, 32'h00, 1'h0);
    a_reg_parity <= 1'h0;
    ex(mk(3'h3, 1'h0, 4'h0, 1'h1, 4'h0, 4'h0, 5'h01, 2'h2, 5'h00, 6'h00));
    chk(32'(d_bus), 32'hc3);
    ex(wc(4'h0, 4'h1));
    chk(32'(dest_strobe), 32'h0);
    rd(REG_STAT, 32'h3, 32'h3, 1'h0);
    wr(REG_CTRL, 32'h3);
    a_reg_parity <= 1'h1;
    check_stop_sw <= 1'h1;
    repeat (6) @(posedge pclk);
    ex(mk(3'h3, 1'h0, 4'h0, 1'h0, 4'h0, 4'h0, A_SRC_STOP, 2'h2, 5'h00, 6'h00));
    rd(REG_STAT, 32'h7, 32'h5, 1'h0);
    results();
  end
endmodule
